/* File: pcrb_bank.v */
// Eight-byte configuration register bank of a programmable PLL clock generator
`timescale 1ns/1ps
`default_nettype none
`include "pcrb_map.vh"
module pcrb_bank #(
    parameter SYNC_VARIANT = 1,
    parameter [13:0] FBK_MIN_LEGAL = 14'h000c
)(
    input wire sys_clk,
    input wire rst_n,
    input wire wr_en,
    input wire [2:0] wr_addr,
    input wire [7:0] wr_data,
    input wire [2:0] rd_addr,
    output reg [7:0] rd_data,
    output reg [11:0] reference_modulus,
    output reg [13:0] feedback_modulus,
    output reg feedback_modulus_bad,
    output reg [3:0] post_divider_one_code,
    output reg [3:0] post_divider_two_code,
    output reg [1:0] post_divider_three_code,
    output reg [4:0] post_divider_one_modulus,
    output reg [4:0] post_divider_two_modulus,
    output reg [3:0] post_divider_three_modulus,
    output reg post_code_bad,
    output reg power_down_a,
    output reg power_down_b,
    output reg reference_input_select,
    output reg feedback_input_select,
    output reg cmos_output_select,
    output reg filter_capacitor_select,
    output reg [1:0] filter_resistor_select,
    output reg [1:0] pump_current_select,
    output reg sync_function_enable,
    output reg sync_edge_polarity
);
    // ****************************************************************
    // Storage
    // ****************************************************************
    reg [7:0] bank [0:`PCRB_NUM_BYTES-1];
    wire [63:0] flat;
    genvar g;
    generate
        for (g = 0; g < `PCRB_NUM_BYTES; g = g + 1)
        begin : gen_byte
            assign flat[g*8 +: 8] = bank[g];
            always @(posedge sys_clk)
            begin
                if (!rst_n)
                    bank[g] <= `PCRB_RESET_BYTE;
                else if (wr_en && wr_addr == g)
                    bank[g] <= wr_data;
            end
        end
    endgenerate

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function [3:0] pcrb_pow2;
        input [1:0] code;
        begin
            pcrb_pow2 = 4'h1 << code;
        end
    endfunction

    function pcrb_code_bad;
        input [3:0] code;
        begin
            pcrb_code_bad = code > `PCRB_POST_CODE_MAX;
        end
    endfunction

    // ****************************************************************
    // Read path and decoded fields
    // ****************************************************************
    always @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            rd_data <= 8'h00;
            reference_modulus <= 12'h000;
            feedback_modulus <= 14'h0000;
            feedback_modulus_bad <= 1'b0;
            post_divider_one_code <= 4'h0;
            post_divider_two_code <= 4'h0;
            post_divider_three_code <= 2'h0;
            post_divider_one_modulus <= 5'h01;
            post_divider_two_modulus <= 5'h01;
            post_divider_three_modulus <= 4'h1;
            post_code_bad <= 1'b0;
            power_down_a <= 1'b0;
            power_down_b <= 1'b0;
            reference_input_select <= 1'b0;
            feedback_input_select <= 1'b0;
            cmos_output_select <= 1'b0;
            filter_capacitor_select <= 1'b0;
            filter_resistor_select <= 2'h0;
            pump_current_select <= 2'h0;
            sync_function_enable <= 1'b0;
            sync_edge_polarity <= 1'b0;
        end
        else
        begin
            rd_data <= bank[rd_addr];
            reference_modulus <=
                flat[`PCRB_REF_MSB:`PCRB_REF_LSB];
            feedback_modulus <=
                flat[`PCRB_FBK_MSB:`PCRB_FBK_LSB];
            // Small moduli cannot lock; flag them for the loop
            feedback_modulus_bad <=
                flat[`PCRB_FBK_MSB:`PCRB_FBK_LSB] < FBK_MIN_LEGAL;
            post_divider_one_code <=
                flat[`PCRB_POST_DIVIDER_ONE_CODE_MSB:`PCRB_POST_DIVIDER_ONE_CODE_LSB];
            post_divider_two_code <=
                flat[`PCRB_POST_DIVIDER_TWO_CODE_MSB:`PCRB_POST_DIVIDER_TWO_CODE_LSB];
            post_divider_one_modulus <=
                {1'b0, flat[`PCRB_POST_DIVIDER_ONE_CODE_MSB:`PCRB_POST_DIVIDER_ONE_CODE_LSB]} + 5'h01;
            post_divider_two_modulus <=
                {1'b0, flat[`PCRB_POST_DIVIDER_TWO_CODE_MSB:`PCRB_POST_DIVIDER_TWO_CODE_LSB]} + 5'h01;
            post_code_bad <=
                pcrb_code_bad(flat[`PCRB_POST_DIVIDER_ONE_CODE_MSB:`PCRB_POST_DIVIDER_ONE_CODE_LSB]) ||
                pcrb_code_bad(flat[`PCRB_POST_DIVIDER_TWO_CODE_MSB:`PCRB_POST_DIVIDER_TWO_CODE_LSB]);
            post_divider_three_code <=
                flat[`PCRB_POST_DIVIDER_THREE_CODE_MSB:`PCRB_POST_DIVIDER_THREE_CODE_LSB];
            post_divider_three_modulus <=
                pcrb_pow2(flat[`PCRB_POST_DIVIDER_THREE_CODE_MSB:`PCRB_POST_DIVIDER_THREE_CODE_LSB]);
            power_down_a <= flat[`PCRB_PD_A_BIT];
            power_down_b <= flat[`PCRB_PD_B_BIT];
            reference_input_select <= flat[`PCRB_REF_SEL_BIT];
            feedback_input_select <= flat[`PCRB_FBK_SEL_BIT];
            cmos_output_select <= flat[`PCRB_CMOS_BIT];
            filter_capacitor_select <= flat[`PCRB_CAP_BIT];
            filter_resistor_select <=
                flat[`PCRB_RES_MSB:`PCRB_RES_LSB];
            pump_current_select <=
                flat[`PCRB_PUMP_MSB:`PCRB_PUMP_LSB];
            // Without sync the bits stay stored but steer nothing
            sync_function_enable <= (SYNC_VARIANT != 0) &&
                flat[`PCRB_SYNC_EN_BIT];
            sync_edge_polarity <= (SYNC_VARIANT != 0) &&
                flat[`PCRB_SYNC_POL_BIT];
        end
    end
endmodule
`default_nettype wire

/* File: pcrb_bank_tb.sv */
// Self-checking bench for the configuration bank
`timescale 1ns/1ps
`default_nettype none
module pcrb_bank_tb;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] d;
    int err_count = 0;
    int num_checks = 0;
    int cyc = 0;
    logic [7:0] pat [8] = '{8'ha5, 8'hea, 8'hb0, 8'hff, 8'hbf, 8'h61, 8'h23, 8'h00};
    wire wr_en, feedback_modulus_bad, post_code_bad, power_down_a, power_down_b;
    wire reference_input_select, feedback_input_select, cmos_output_select;
    wire filter_capacitor_select, sync_function_enable, sync_edge_polarity;
    wire [2:0] wr_addr, rd_addr;
    wire [7:0] wr_data, rd_data;
    wire [11:0] reference_modulus;
    wire [13:0] feedback_modulus;
    wire [3:0] post_divider_one_code, post_divider_two_code, post_divider_three_modulus;
    wire [4:0] post_divider_one_modulus, post_divider_two_modulus;
    wire [1:0] post_divider_three_code, filter_resistor_select, pump_current_select;
    pcrb_bank dut_u (.*);
    pcrb_master m_u (.*);
    always #2 sys_clk = ~sys_clk;
    task report_and_stop;
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task chk(input string n, input logic [31:0] s, input logic [31:0] e);
        num_checks++;
        if (s !== e)
        begin
            err_count++;
            $display("[FAIL] %s exp %h got %h", n, e, s);
        end
    endtask
    always @(posedge sys_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 3000)
        begin
            err_count++;
            report_and_stop;
        end
    end
    initial
    begin
        repeat (20) @(posedge sys_clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 8; i++)
            m_u.wr(3'(i), pat[i]);
        for (int i = 0; i < 8; i++)
        begin
            m_u.rd(3'(i), d);
            chk("readback", 32'(d), 32'(pat[i]));
        end
        chk("ref", {reference_input_select, reference_modulus}, 32'h0aa5);
        chk("post", {post_divider_three_modulus, post_divider_two_modulus,
            post_divider_one_modulus}, {4'h8, 5'hc, 5'h1});
        chk("fbk", {cmos_output_select, feedback_input_select, feedback_modulus},
            32'hbfff);
        chk("loop", {filter_capacitor_select, filter_resistor_select,
            pump_current_select}, 32'h19);
        chk("power", {power_down_a, power_down_b, sync_function_enable,
            sync_edge_polarity, post_code_bad, feedback_modulus_bad}, 32'h3c);
        m_u.wr(3'h1, 8'h10);
        m_u.wr(3'h4, 8'h40);
        @(posedge sys_clk);
        @(negedge sys_clk);
        chk("select", {post_divider_three_modulus, power_down_a, reference_input_select,
            feedback_input_select, cmos_output_select}, 32'h16);
        m_u.wr(3'h3, 8'h05);
        m_u.wr(3'h6, 8'h02);
        m_u.wr(3'h2, 8'h3a);
        @(posedge sys_clk);
        @(negedge sys_clk);
        chk("fbk small", 32'(feedback_modulus), 32'h5);
        chk("codes", {post_divider_two_code, post_divider_one_code,
            post_divider_three_code, feedback_modulus_bad, sync_function_enable,
            sync_edge_polarity}, 32'h745);
        chk("post mod", {post_divider_two_modulus, post_divider_one_modulus},
            32'h8b);
        @(posedge sys_clk);
        rst_n <= 1'b0;
        @(posedge sys_clk);
        rst_n <= 1'b1;
        m_u.rd(3'h4, d);
        chk("reset", {d, power_down_b, post_divider_one_modulus}, 32'h1);
        report_and_stop;
    end
endmodule
`default_nettype wire

/* File: pcrb_checker_assertions.sv */
// Concurrent checks on the configuration bank ports
`timescale 1ns/1ps
`default_nettype none
module pcrb_checker (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic wr_en,
    input wire logic [2:0] wr_addr,
    input wire logic [7:0] wr_data,
    input wire logic [2:0] rd_addr,
    input wire logic [7:0] rd_data,
    input wire logic [13:0] feedback_modulus,
    input wire logic [3:0] post_divider_two_code,
    input wire logic [4:0] post_divider_two_modulus,
    input wire logic [1:0] post_divider_three_code,
    input wire logic [3:0] post_divider_three_modulus,
    input wire logic power_down_a,
    input wire logic power_down_b,
    input wire logic reference_input_select,
    input wire logic [1:0] filter_resistor_select
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    sequence s_wr_then_sel;
        wr_en ##1 rd_addr == $past(wr_addr);
    endsequence
    a_fbk_low: assert property (wr_en && wr_addr == 3'h3 |-> ##2
        feedback_modulus[7:0] == $past(wr_data, 2)) else $error("fbk low");
    a_fbk_high: assert property (wr_en && wr_addr == 3'h4 |-> ##2
        feedback_modulus[13:8] == $past(wr_data[5:0], 2)) else $error("fbk hi");
    a_post_divider_three_code_decode: assert property (post_divider_three_modulus ==
        4'h1 << post_divider_three_code) else $error("post_divider_three_code modulus");
    a_post_divider_two_code_plus: assert property (post_divider_two_modulus ==
        {1'b0, post_divider_two_code} + 5'h1) else $error("post_divider_two_code modulus");
    a_byte1_fields: assert property (wr_en && wr_addr == 3'h1 |-> ##2
        {power_down_a, reference_input_select} == $past(wr_data[5:4], 2))
        else $error("byte1 fields");
    a_shut_b: assert property (wr_en && wr_addr == 3'h6 |-> ##2
        power_down_b == $past(wr_data[5], 2)) else $error("power down b");
    a_resistor_sel: assert property (wr_en && wr_addr == 3'h5 |-> ##2
        filter_resistor_select == $past(wr_data[5:4], 2)) else $error("resistor");
    a_read_back: assert property (s_wr_then_sel |=>
        rd_data == $past(wr_data, 2)) else $error("read back");
    a_reset_clear: assert property (disable iff (1'b0) $rose(rst_n) |->
        rd_data == 8'h00 && feedback_modulus == 14'h0000) else $error("reset");
endmodule
bind pcrb_bank pcrb_checker chk_u (.*);
`default_nettype wire

/* File: pcrb_map.vh */
// Register map, field positions and reset values of the PLL configuration bank
// Function
// - Feedback modulus is 14 bits, bits 37:24; disallowed values are flagged.
// - Third post divider code at bits 15:14 divides by 1, 2, 4, 8.
// - Power-down bits 13 and 53: zero normal, one powered down.
// - Bit 12 selects crystal (0) or external reference pin (1).
// - Bit 38 feeds VCO (0) or post divider output (1) back.
// - Post divider one/two codes at 19:16, 23:20; modulus is code plus one.
// - Capacitor select bit 46, resistor select 45:44, pump current 41:40.
// - Reference modulus is 12 bits at bits 11:0.
// - Bit 39 selects pseudo-ECL outputs (0) or CMOS outputs (1).
// - Sync variant: bit 48 enables sync, bit 49 picks the edge.
// - All bits clear to zero at reset and read back as written.
`ifndef PCRB_MAP_VH
`define PCRB_MAP_VH
`define PCRB_ADDR_W 3
`define PCRB_NUM_BYTES 8
`define PCRB_ADDR_REF_LOW 3'h0
`define PCRB_ADDR_REF_HIGH 3'h1
`define PCRB_ADDR_POST12 3'h2
`define PCRB_ADDR_FBK_LOW 3'h3
`define PCRB_ADDR_FBK_HIGH 3'h4
`define PCRB_ADDR_LOOP 3'h5
`define PCRB_ADDR_PWR_SYNC 3'h6
`define PCRB_ADDR_RSVD 3'h7
`define PCRB_RESET_BYTE 8'h00
`define PCRB_REF_LSB 0
`define PCRB_REF_MSB 11
`define PCRB_REF_SEL_BIT 12
`define PCRB_PD_A_BIT 13
`define PCRB_POST_DIVIDER_THREE_CODE_LSB 14
`define PCRB_POST_DIVIDER_THREE_CODE_MSB 15
`define PCRB_POST_DIVIDER_ONE_CODE_LSB 16
`define PCRB_POST_DIVIDER_ONE_CODE_MSB 19
`define PCRB_POST_DIVIDER_TWO_CODE_LSB 20
`define PCRB_POST_DIVIDER_TWO_CODE_MSB 23
`define PCRB_FBK_LSB 24
`define PCRB_FBK_MSB 37
`define PCRB_FBK_SEL_BIT 38
`define PCRB_CMOS_BIT 39
`define PCRB_PUMP_LSB 40
`define PCRB_PUMP_MSB 41
`define PCRB_RES_LSB 44
`define PCRB_RES_MSB 45
`define PCRB_CAP_BIT 46
`define PCRB_SYNC_EN_BIT 48
`define PCRB_SYNC_POL_BIT 49
`define PCRB_PD_B_BIT 53
`define PCRB_POST_CODE_MAX 4'hb
`endif

/* File: pcrb_master.sv */
// Byte access master model for the configuration bank
`timescale 1ns/1ps
`default_nettype none
module pcrb_master (
    input wire logic sys_clk,
    input wire logic [7:0] rd_data,
    output var logic wr_en = 1'b0,
    output var logic [2:0] wr_addr = 3'h0,
    output var logic [7:0] wr_data = 8'h00,
    output var logic [2:0] rd_addr = 3'h0
);
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        wr_en <= 1'b1;
        wr_addr <= a;
        wr_data <= d;
        @(posedge sys_clk);
        wr_en <= 1'b0;
        wr_data <= ~d;
    endtask
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        rd_addr <= a;
        @(posedge sys_clk);
        @(negedge sys_clk);
        d = rd_data;
    endtask
endmodule
`default_nettype wire
